/* File: verilog/env_consts.svh */
// constants for the three-envelope ADSR block
// assumes one 125 MHz clock and an 8-bit register port
`ifndef ENV_CONSTS_SVH
`define ENV_CONSTS_SVH
// -----------------------------------------------------------------
// register map
// -----------------------------------------------------------------
`define ADDR_ENV_END 8'h30
`define OFS_TRIG 4'h0
`define OFS_PRM_FIRST 4'h1
`define OFS_PRM_LAST 4'h8
`define OFS_STAGE 4'h9
`define OFS_LEVEL 4'ha
`define ADDR_CURVE_CTRL 8'h30
`define ADDR_FADER_FIRST 8'h31
`define ADDR_FADER_LAST 8'h34
`define ADDR_FADER_SEL 8'h35
`define ADDR_CUT_BASE 8'h36
`define ADDR_CUT_DEPTH 8'h37
`define CURVE_PRESS_BIT 0
// -----------------------------------------------------------------
// reset values and the flat curve setting
// -----------------------------------------------------------------
`define RST_ATTACK 8'h00
`define RST_DECAY 8'h80
`define RST_SUSTAIN 8'h80
`define RST_RELEASE 8'h80
`define RST_CURVE_A 8'h80
`define RST_CURVE_D 8'h00
`define RST_CURVE_S 8'h80
`define RST_CURVE_R 8'h00
`define RST_CUT_BASE 8'h00
`define RST_CUT_DEPTH 8'h80
`define CURVE_FLAT 8'h80
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CLK_MHZ 125
`define ENV_TICK_NS 1000
`define ENV_TICK_CYC ((`ENV_TICK_NS * `CLK_MHZ) / 1000)
`endif

/* File: verilog/env_pkg.sv */
// types shared by the envelope block
// assumes nothing beyond the tool's package support
package env_pkg;
  // 0 is shortest or lowest
  typedef logic [7:0] param_t;
  typedef enum logic [2:0] {
    TRIG_KEY = 3'h0,
    TRIG_LFO1 = 3'h1,
    TRIG_LFO2 = 3'h2,
    TRIG_LOOP = 3'h3,
    TRIG_SEQ = 3'h4
  } trig_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ATTACK = 3'h1,
    ST_DECAY = 3'h3,
    ST_SUSTAIN = 3'h2,
    ST_RELEASE = 3'h6
  } stage_t;
endpackage

/* File: verilog/env_param_if.sv */
// parameter set passed from the fader router to the envelope top
// assumes env_pkg is compiled first
interface env_param_if;
  import env_pkg::*;
  trig_mode_t trig_mode [3];
  param_t prm [3][8];
  logic curve_mode;
  logic [1:0] fader_sel;
  modport router (output trig_mode, output prm, output curve_mode, output fader_sel);
  modport user (input trig_mode, input prm, input curve_mode, input fader_sel);
endinterface

/* File: verilog/fader_router.sv */
// parameter storage and fader steering for the three envelopes
// assumes single-cycle write strobes on the register port
`include "env_consts.svh"
module fader_router (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // register writes
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  // parameter set
  env_param_if.router pif
);
  import env_pkg::*;

  logic [1:0] lane;
  assign lane = 2'(addr - `ADDR_FADER_FIRST);

  function automatic param_t rst_val(int p);
    case (p)
      0: return `RST_ATTACK;
      1: return `RST_DECAY;
      2: return `RST_SUSTAIN;
      3: return `RST_RELEASE;
      4: return `RST_CURVE_A;
      5: return `RST_CURVE_D;
      6: return `RST_CURVE_S;
      default: return `RST_CURVE_R;
    endcase
  endfunction

  // parameter and trigger mode storage
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int e = 0; e < 3; e++) begin
        pif.trig_mode[e] <= TRIG_KEY;
        for (int p = 0; p < 8; p++) pif.prm[e][p] <= rst_val(p);
      end
    end else if (ce && wr) begin
      if (addr < `ADDR_ENV_END) begin
        if (addr[3:0] == `OFS_TRIG && wdata[2:0] <= 3'h4) begin
          pif.trig_mode[addr[5:4]] <= trig_mode_t'(wdata[2:0]);
        end else if (addr[3:0] >= `OFS_PRM_FIRST && addr[3:0] <= `OFS_PRM_LAST) begin
          pif.prm[addr[5:4]][3'(addr[3:0] - `OFS_PRM_FIRST)] <= wdata;
        end
      end else if (addr >= `ADDR_FADER_FIRST && addr <= `ADDR_FADER_LAST) begin
        pif.prm[pif.fader_sel][{pif.curve_mode, lane}] <= wdata;
      end
    end
  end

  // curve switch toggles on each press
  always_ff @(posedge clock) begin
    if (reset) begin
      pif.curve_mode <= 1'b0;
    end else if (ce && wr && addr == `ADDR_CURVE_CTRL && wdata[`CURVE_PRESS_BIT]) begin
      pif.curve_mode <= !pif.curve_mode;
    end
  end

  // envelope that the faders address
  always_ff @(posedge clock) begin
    if (reset) begin
      pif.fader_sel <= 2'h0;
    end else if (ce && wr && addr == `ADDR_FADER_SEL && wdata[1:0] != 2'h3) begin
      pif.fader_sel <= wdata[1:0];
    end
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (reset);

  curve_press_toggle_a: assert property (
    ce && wr && addr == `ADDR_CURVE_CTRL && wdata[`CURVE_PRESS_BIT]
    |=> pif.curve_mode != $past(pif.curve_mode))
    else $error("curve press did not toggle curve mode");
  fader_time_route_a: assert property (
    ce && wr && addr == `ADDR_FADER_FIRST && !pif.curve_mode && pif.fader_sel == 2'h0
    |=> pif.prm[0][0] == $past(wdata))
    else $error("attack fader did not reach attack parameter");
endmodule

/* File: verilog/env_core.sv */
// one four-stage envelope generator
// assumes tick is a one-cycle pulse and trig wins over every other event
`include "env_consts.svh"
module env_core (
  // clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  input wire logic tick,
  // note events
  input wire logic trig,
  input wire logic gate,
  input wire logic loop_skip,
  input wire logic self_loop,
  // stage params 0..3, curves 4..7
  input wire env_pkg::param_t prm [8],
  // state
  output env_pkg::stage_t stage_reg,
  output logic [7:0] level_reg
);
  import env_pkg::*;

  logic [8:0] cnt_reg;
  logic [8:0] period;
  logic step;

  // ticks per level step, stretched by curve as level grows
  function automatic logic [8:0] stage_period(param_t base, param_t shape, logic [7:0] lvl);
    logic [15:0] prod;
    prod = shape * lvl;
    return {1'b0, base} + {1'b0, prod[15:8]};
  endfunction

  // per-stage period, each with its own curve
  always_comb begin
    case (stage_reg)
      ST_ATTACK: period = stage_period(prm[0], prm[4], level_reg);
      ST_DECAY: period = stage_period(prm[1], prm[5], level_reg);
      ST_SUSTAIN: period = {1'b0, 8'hff - prm[6]};
      ST_RELEASE: period = stage_period(prm[3], prm[7], level_reg);
      default: period = 9'h000;
    endcase
  end
  assign step = tick && cnt_reg >= period;

  // tick counter within a level step
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_reg <= 9'h000;
    end else if (ce) begin
      if (trig || step) cnt_reg <= 9'h000;
      else if (tick && cnt_reg != 9'h1ff) cnt_reg <= cnt_reg + 9'h001;
    end
  end

  // stage sequencing
  always_ff @(posedge clock) begin
    if (reset) begin
      stage_reg <= ST_IDLE;
    end else if (ce) begin
      if (trig) begin
        stage_reg <= ST_ATTACK;
      end else begin
        case (stage_reg)
          ST_ATTACK: begin
            if (!gate && !loop_skip) stage_reg <= ST_RELEASE;
            else if (step && level_reg == 8'hff) stage_reg <= ST_DECAY;
          end
          ST_DECAY: begin
            if (!gate && !loop_skip) stage_reg <= ST_RELEASE;
            else if (level_reg <= prm[2]) begin
              stage_reg <= loop_skip ? ST_RELEASE : ST_SUSTAIN;
            end
          end
          ST_SUSTAIN: begin
            if (!gate || loop_skip) stage_reg <= ST_RELEASE;
          end
          ST_RELEASE: begin
            if (level_reg == 8'h00) stage_reg <= self_loop ? ST_ATTACK : ST_IDLE;
          end
          default: stage_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // output level, kept on retrigger
  always_ff @(posedge clock) begin
    if (reset) begin
      level_reg <= 8'h00;
    end else if (ce && step && !trig) begin
      case (stage_reg)
        ST_ATTACK: if (level_reg != 8'hff) level_reg <= level_reg + 8'h01;
        ST_DECAY: if (level_reg > prm[2]) level_reg <= level_reg - 8'h01;
        ST_SUSTAIN: begin
          if (prm[6] > `CURVE_FLAT && level_reg != 8'h00) level_reg <= level_reg - 8'h01;
        end
        ST_RELEASE: if (level_reg != 8'h00) level_reg <= level_reg - 8'h01;
        default: level_reg <= level_reg;
      endcase
    end
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (reset);

  loop_restart_a: assert property (
    ce && !trig && self_loop && stage_reg == ST_RELEASE && level_reg == 8'h00
    |=> stage_reg == ST_ATTACK)
    else $error("loop mode did not restart after release");
  attack_rise_a: assert property (
    ce && !trig && stage_reg == ST_ATTACK |=> level_reg >= $past(level_reg))
    else $error("level fell during attack");
  sustain_skip_a: assert property (
    ce && !trig && loop_skip && stage_reg == ST_DECAY && level_reg <= prm[2]
    |=> stage_reg == ST_RELEASE)
    else $error("looping mode entered sustain");
endmodule

/* File: verilog/adsr_envelope_generator.sv */
// three envelope generators with trigger select and register port
// assumes trigger inputs are one-cycle pulses synchronous to clock
//
// Chosen here: strobed register access and the register addresses.
`include "env_consts.svh"
module adsr_envelope_generator (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // trigger sources
  input wire logic key_press,
  input wire logic key_gate,
  input wire logic lfo1_cycle,
  input wire logic lfo2_cycle,
  input wire logic seq_step,
  // control outputs
  output logic [7:0] amp_env_out,
  output logic [7:0] filter_cutoff_out,
  output logic [7:0] mod_env_out,
  output logic curve_led
);
  import env_pkg::*;

  // ---------------------------------------------------------------
  // shared signals
  // ---------------------------------------------------------------
  env_param_if pif ();

  logic [7:0] tick_cnt_reg;
  logic tick_reg;
  logic trig_w [3];
  logic skip_w [3];
  logic self_w [3];
  stage_t stage_w [3];
  logic [7:0] level_w [3];
  param_t cut_base_reg;
  param_t cut_depth_reg;
  logic [15:0] cut_prod;
  logic [8:0] cut_sum;
  logic [7:0] rd_val;
  logic [1:0] env_idx;

  // trigger decode, one mode per envelope
  function automatic logic trig_hit(trig_mode_t m, logic k, logic l1, logic l2,
                                    logic sq);
    case (m)
      TRIG_KEY: return k;
      TRIG_LFO1: return l1;
      TRIG_LFO2: return l2;
      TRIG_LOOP: return k;
      TRIG_SEQ: return sq;
      default: return 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // envelope time base
  // ---------------------------------------------------------------

  // one tick every envelope time unit
  always_ff @(posedge clock) begin
    if (reset) begin
      tick_cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else if (ce) begin
      if (tick_cnt_reg == 8'(`ENV_TICK_CYC - 1)) begin
        tick_cnt_reg <= 8'h00;
        tick_reg <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 8'h01;
        tick_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // parameter storage
  // ---------------------------------------------------------------
  fader_router router (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .wr(wr),
    .addr(addr),
    .wdata(wdata),
    .pif(pif)
  );

  // ---------------------------------------------------------------
  // envelope generators: amplitude, filter, modulation
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : gen_env
    // independent trigger per envelope
    assign trig_w[g] = trig_hit(pif.trig_mode[g], key_press, lfo1_cycle,
                                lfo2_cycle, seq_step);
    assign skip_w[g] = pif.trig_mode[g] != TRIG_KEY;
    assign self_w[g] = pif.trig_mode[g] == TRIG_LOOP;

    env_core core (
      .clock(clock),
      .reset(reset),
      .ce(ce),
      .tick(tick_reg),
      .trig(trig_w[g]),
      .gate(key_gate),
      .loop_skip(skip_w[g]),
      .self_loop(self_w[g]),
      .prm(pif.prm[g]),
      .stage_reg(stage_w[g]),
      .level_reg(level_w[g])
    );

    key_start_a: assert property (
      @(posedge clock) disable iff (reset)
      ce && key_press && pif.trig_mode[g] == TRIG_KEY |=> stage_w[g] == ST_ATTACK)
      else $error("key press did not start attack");
    lfo1_start_a: assert property (
      @(posedge clock) disable iff (reset)
      ce && lfo1_cycle && pif.trig_mode[g] == TRIG_LFO1 |=> stage_w[g] == ST_ATTACK)
      else $error("first lfo cycle did not start attack");
    lfo2_start_a: assert property (
      @(posedge clock) disable iff (reset)
      ce && lfo2_cycle && pif.trig_mode[g] == TRIG_LFO2 |=> stage_w[g] == ST_ATTACK)
      else $error("second lfo cycle did not start attack");
    seq_start_a: assert property (
      @(posedge clock) disable iff (reset)
      ce && seq_step && pif.trig_mode[g] == TRIG_SEQ |=> stage_w[g] == ST_ATTACK)
      else $error("sequencer step did not start attack");
    retrig_no_jump_a: assert property (
      @(posedge clock) disable iff (reset)
      ce && trig_w[g] |=> level_w[g] == $past(level_w[g]))
      else $error("retrigger changed the level");
    key_release_a: assert property (
      @(posedge clock) disable iff (reset)
      ce && !trig_w[g] && !key_gate && pif.trig_mode[g] == TRIG_KEY
      && stage_w[g] inside {ST_ATTACK, ST_DECAY, ST_SUSTAIN}
      |=> stage_w[g] == ST_RELEASE)
      else $error("key release did not enter release");
    sustain_hold_a: assert property (
      @(posedge clock) disable iff (reset)
      ce && !trig_w[g] && key_gate && stage_w[g] == ST_SUSTAIN
      && pif.trig_mode[g] == TRIG_KEY && pif.prm[g][6] <= `CURVE_FLAT
      |=> level_w[g] == $past(level_w[g]) && stage_w[g] == ST_SUSTAIN)
      else $error("sustain level moved while held");
  end

  // ---------------------------------------------------------------
  // filter cutoff from base plus scaled envelope
  // ---------------------------------------------------------------

  // base plus depth times filter envelope
  always_comb begin
    cut_prod = cut_depth_reg * level_w[1];
    cut_sum = {1'b0, cut_base_reg} + {1'b0, cut_prod[15:8]};
  end

  // cutoff base and depth registers
  always_ff @(posedge clock) begin
    if (reset) begin
      cut_base_reg <= `RST_CUT_BASE;
      cut_depth_reg <= `RST_CUT_DEPTH;
    end else if (ce && wr) begin
      if (addr == `ADDR_CUT_BASE) cut_base_reg <= wdata;
      else if (addr == `ADDR_CUT_DEPTH) cut_depth_reg <= wdata;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  // registered control outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      amp_env_out <= 8'h00;
      filter_cutoff_out <= 8'h00;
      mod_env_out <= 8'h00;
      curve_led <= 1'b0;
    end else if (ce) begin
      amp_env_out <= level_w[0];
      filter_cutoff_out <= cut_sum[8] ? 8'hff : cut_sum[7:0];
      mod_env_out <= level_w[2];
      curve_led <= pif.curve_mode;
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  assign env_idx = addr[5:4];

  // read decode, unmapped reads give zero
  always_comb begin
    rd_val = 8'h00;
    if (addr < `ADDR_ENV_END) begin
      if (addr[3:0] == `OFS_TRIG) begin
        rd_val = {5'h00, pif.trig_mode[env_idx]};
      end else if (addr[3:0] >= `OFS_PRM_FIRST && addr[3:0] <= `OFS_PRM_LAST) begin
        rd_val = pif.prm[env_idx][3'(addr[3:0] - `OFS_PRM_FIRST)];
      end else if (addr[3:0] == `OFS_STAGE) begin
        rd_val = {5'h00, stage_w[env_idx]};
      end else if (addr[3:0] == `OFS_LEVEL) begin
        rd_val = level_w[env_idx];
      end
    end else if (addr == `ADDR_CURVE_CTRL) begin
      rd_val = {7'h00, pif.curve_mode};
    end else if (addr == `ADDR_FADER_SEL) begin
      rd_val = {6'h00, pif.fader_sel};
    end else if (addr == `ADDR_CUT_BASE) begin
      rd_val = cut_base_reg;
    end else if (addr == `ADDR_CUT_DEPTH) begin
      rd_val = cut_depth_reg;
    end
  end

  // read data stands one cycle only
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= rd ? rd_val : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks on outputs
  // ---------------------------------------------------------------
  cutoff_floor_a: assert property (
    @(posedge clock) disable iff (reset)
    ce |=> filter_cutoff_out >= $past(cut_base_reg))
    else $error("cutoff below base setting");
  led_follow_a: assert property (
    @(posedge clock) disable iff (reset)
    ce |=> curve_led == $past(pif.curve_mode))
    else $error("curve lamp does not follow curve mode");

  sustain_seen_c: cover property (
    @(posedge clock) disable iff (reset) stage_w[0] == ST_SUSTAIN);
  loop_cycle_c: cover property (
    @(posedge clock) disable iff (reset)
    stage_w[2] == ST_RELEASE ##1 stage_w[2] == ST_ATTACK);
  curve_on_c: cover property (
    @(posedge clock) disable iff (reset) $rose(curve_led));
endmodule

/* File: tb/trig_source_model.sv */
// trigger source model: keyboard, both LFOs and control sequencer
// assumes the bench raises go for one cycle per requested event
module trig_source_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // request from bench: 0 key, 1 lfo one, 2 lfo two, 3 sequencer
  input wire logic go,
  input wire logic [1:0] src,
  input wire logic hold,
  // events to the block
  output logic key_press,
  output logic key_gate,
  output logic lfo1_cycle,
  output logic lfo2_cycle,
  output logic seq_step
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle event pulse per request
  always_ff @(posedge clock) begin
    key_press <= !reset && go && src == 2'h0;
    lfo1_cycle <= !reset && go && src == 2'h1;
    lfo2_cycle <= !reset && go && src == 2'h2;
    seq_step <= !reset && go && src == 2'h3;
  end
  // key held level
  always_ff @(posedge clock) begin
    key_gate <= !reset && hold;
  end
endmodule

/* File: tb/adsr_envelope_generator_tb_top.sv */
// self-checking bench for the three-envelope block
// assumes the register port answers one cycle after a read strobe
module adsr_envelope_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ce = 1'b1;
  logic go = 1'b0;
  logic hold = 1'b0;
  logic [1:0] src = 2'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] got;
  logic [7:0] lvl;
  logic key_press, key_gate, lfo1_cycle, lfo2_cycle, seq_step, curve_led;
  logic [7:0] rdata, amp_env_out, filter_cutoff_out, mod_env_out;
  logic [7:0] rst_vals [10] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h80,
    8'h00, 8'h00};
  int n_errors = 0;
  int checks_done = 0;
  // -----------------------------------------------------------------
  // clock, design and event sources
  // -----------------------------------------------------------------
  always #4 clock = ~clock;
  adsr_envelope_generator u_adsr_envelope_generator (.clock(clock), .reset(reset),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .key_press(key_press), .key_gate(key_gate), .lfo1_cycle(lfo1_cycle),
    .lfo2_cycle(lfo2_cycle), .seq_step(seq_step), .amp_env_out(amp_env_out),
    .filter_cutoff_out(filter_cutoff_out), .mod_env_out(mod_env_out),
    .curve_led(curve_led));
  trig_source_model u_trig_source_model (.clock(clock), .reset(reset), .go(go),
    .src(src), .hold(hold), .key_press(key_press), .key_gate(key_gate),
    .lfo1_cycle(lfo1_cycle), .lfo2_cycle(lfo2_cycle), .seq_step(seq_step));
  // -----------------------------------------------------------------
  // bus, event and compare tasks
  // -----------------------------------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask
  task automatic check8(input logic [7:0] g, input logic [7:0] e, input string what);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, g, e);
    end
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    reg_read(a);
    check8(got, e, "register read");
  endtask
  task automatic fire(input logic [1:0] s);
    @(posedge clock);
    go <= 1'b1;
    src <= s;
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic do_reset();
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog well beyond the longest envelope walk
  initial begin
    #(90000 * 8);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    do_reset();
    // reset values, unmapped and refused writes
    foreach (rst_vals[i]) begin
      expect_reg(8'(i), rst_vals[i]);
    end
    expect_reg(8'h40, 8'h00);
    reg_write(8'h00, 8'h05);
    expect_reg(8'h00, 8'h00);
    // curve mode steers the faders
    reg_write(8'h30, 8'h01);
    expect_reg(8'h30, 8'h01);
    check8({7'h00, curve_led}, 8'h01, "lamp on");
    reg_write(8'h31, 8'h40);
    expect_reg(8'h05, 8'h40);
    expect_reg(8'h01, 8'h00);
    reg_write(8'h30, 8'h01);
    expect_reg(8'h30, 8'h00);
    check8({7'h00, curve_led}, 8'h00, "lamp off");
    reg_write(8'h34, 8'h22);
    expect_reg(8'h04, 8'h22);
    expect_reg(8'h08, 8'h00);
    reg_write(8'h31, 8'h07);
    expect_reg(8'h01, 8'h07);
    reg_write(8'h35, 8'h02);
    reg_write(8'h33, 8'h11);
    expect_reg(8'h23, 8'h11);
    expect_reg(8'h03, 8'h80);
    $display("test registers and curves done");
    // each envelope answers its own source and ignores the key and the sources fired before it
    reg_write(8'h00, 8'h01);
    reg_write(8'h10, 8'h02);
    reg_write(8'h20, 8'h04);
    fire(2'h0);
    for (int i = 0; i < 3; i++) begin
      expect_reg(8'(i * 16 + 9), 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      fire(2'(i + 1));
      expect_reg(8'(i * 16 + 9), 8'h01);
      if (i < 2) begin
        expect_reg(8'(i * 16 + 25), 8'h00);
      end
    end
    $display("test trigger modes done");
    // key note walk with fast attack and decay
    do_reset();
    reg_write(8'h20, 8'h03);
    // filter envelope kept idle so cutoff shows its base alone
    reg_write(8'h10, 8'h01);
    // looping envelope: fastest attack and release, sustain at top
    reg_write(8'h23, 8'hff);
    reg_write(8'h24, 8'h00);
    reg_write(8'h25, 8'h00);
    reg_write(8'h05, 8'h00);
    reg_write(8'h02, 8'h00);
    reg_write(8'h03, 8'hf0);
    hold <= 1'b1;
    fire(2'h0);
    expect_reg(8'h09, 8'h01);
    expect_reg(8'h29, 8'h01);
    repeat (2000) @(posedge clock);
    reg_read(8'h0a);
    lvl = got;
    fire(2'h0);
    expect_reg(8'h09, 8'h01);
    reg_read(8'h0a);
    check8({7'h00, got >= lvl && lvl != 8'h00}, 8'h01, "level jumped");
    reg_write(8'h36, 8'h20);
    repeat (3) @(posedge clock);
    #1;
    check8(filter_cutoff_out, 8'h20, "cutoff base");
    for (int n = 0; n < 40000 && amp_env_out !== 8'hff; n++) begin
      @(posedge clock);
    end
    check8(amp_env_out, 8'hff, "attack top");
    repeat (2500) @(posedge clock);
    expect_reg(8'h09, 8'h02);
    check8(amp_env_out, 8'hf0, "sustain level");
    hold <= 1'b0;
    repeat (3) @(posedge clock);
    expect_reg(8'h09, 8'h06);
    $display("test key walk done");
    // looping envelope skips sustain, then restarts at release end
    expect_reg(8'h29, 8'h06);
    @(posedge clock);
    ce <= 1'b0;
    @(posedge clock);
    #1;
    lvl = mod_env_out;
    repeat (300) @(posedge clock);
    #1;
    check8(mod_env_out, lvl, "clock enable freeze");
    @(posedge clock);
    ce <= 1'b1;
    for (int n = 0; n < 35000 && mod_env_out !== 8'h00; n++) begin
      @(posedge clock);
    end
    check8(mod_env_out, 8'h00, "release end");
    expect_reg(8'h29, 8'h01);
    $display("test loop mode done");
    stop_test();
  end
endmodule
